//--- mpr_pkg.sv
/*
  Package for the MAC port receive configuration and status block.
  Holds register indexes, field widths, reset values and timing constants.
  Assumes a 100 MHz system clock and a 10 Mb/s line rate.
*/
package mpr_pkg;

  // Register indexes as seen on the register access port.
  localparam logic [7:0] MPR_IDX_LEN_ERR_CNT = 8'hA6;
  localparam logic [7:0] MPR_IDX_GAP_ERR_CNT = 8'hAE;
  localparam logic [7:0] MPR_IDX_LOOPBACK = 8'hB3;
  localparam logic [7:0] MPR_IDX_FCS_CHECK = 8'hB4;
  localparam logic [7:0] MPR_IDX_GAP_MIN = 8'hB5;
  localparam logic [7:0] MPR_IDX_LEN_UPPER = 8'hB6;
  localparam logic [7:0] MPR_IDX_LEN_LOWER = 8'hB7;
  localparam logic [7:0] MPR_IDX_LO_FRAMES = 8'hB8;
  localparam logic [7:0] MPR_IDX_HI_FRAMES = 8'hB9;
  localparam logic [7:0] MPR_IDX_LO_HALFWORDS = 8'hBA;
  localparam logic [7:0] MPR_IDX_HI_HALFWORDS = 8'hBB;

  // Field widths.
  localparam int MPR_ADDR_W = 8;
  localparam int MPR_DATA_W = 32;
  localparam int MPR_GAP_W = 6;
  localparam int MPR_LEN_W = 16;
  localparam int MPR_FRAMES_W = 9;
  localparam int MPR_HALFWORDS_W = 14;
  localparam int MPR_NIBBLE_W = 4;
  localparam int MPR_GAP_BITS_W = 10;

  // Reset values.
  localparam logic MPR_RST_LOOPBACK = 1'b0;
  localparam logic MPR_RST_FCS_CHECK = 1'b1;
  localparam logic [MPR_GAP_W-1:0] MPR_RST_GAP_MIN = 6'hA;
  localparam logic [MPR_LEN_W-1:0] MPR_RST_LEN_UPPER = 16'h0618;
  localparam logic [MPR_LEN_W-1:0] MPR_RST_LEN_LOWER = 16'h0040;

  // Gap field is counted in units of this many bit times.
  localparam int MPR_GAP_UNIT_BITS = 8;

  // Timing: one bit time at 10 Mb/s against the system clock period.
  localparam int MPR_CLK_PERIOD_NS = 10;
  localparam int MPR_BIT_TIME_NS = 100;
  localparam int MPR_BIT_CYCLES = (MPR_BIT_TIME_NS + MPR_CLK_PERIOD_NS - 1) / MPR_CLK_PERIOD_NS;

endpackage

//--- mpr_err_counter.sv
/*
  Thirty-two bit error event counter.
  Assumes the increment is a one-cycle pulse in the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module mpr_err_counter #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Counter wraps at the top, as free counters do.
  assign count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
  assign count_o = count_r;

  // Count one per event.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (inc_i) begin
      count_r <= count_nxt;
    end
  end

endmodule
`default_nettype wire

//--- mpr_gap_check.sv
/*
  Receive interframe gap measurement.
  Assumes the receive data valid level is synchronous to the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mpr_gap_check
  import mpr_pkg::*;
#(
  parameter int BIT_CYCLES = MPR_BIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_dv_i,
  input wire logic [MPR_GAP_W-1:0] gap_min_units_i,
  output logic gap_short_o,
  output logic frame_start_o
);

  localparam int DIV_W = $clog2(BIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES - 1);
  localparam logic [MPR_GAP_BITS_W-1:0] GAP_MAX = '1;

  logic [DIV_W-1:0] div_r;
  logic [MPR_GAP_BITS_W-1:0] gap_bits_r;
  logic dv_d_r;
  logic bit_tick;
  logic [MPR_GAP_BITS_W-1:0] gap_limit;

  // One enable pulse per bit time; the gap is counted in these.
  assign bit_tick = (div_r == DIV_LAST);
  assign gap_limit = MPR_GAP_BITS_W'(gap_min_units_i) * MPR_GAP_BITS_W'(MPR_GAP_UNIT_BITS);
  assign frame_start_o = rx_dv_i & ~dv_d_r;
  assign gap_short_o = frame_start_o & ~(gap_bits_r > gap_limit);

  // Bit time divider, restarted at each edge of data valid.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else if (bit_tick || (rx_dv_i != dv_d_r)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // Gap counter saturates, so the first frame after reset is never short.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_bits_r <= GAP_MAX;
      dv_d_r <= 1'b0;
    end else begin
      dv_d_r <= rx_dv_i;
      if (rx_dv_i) begin
        gap_bits_r <= '0;
      end else if (bit_tick && gap_bits_r != GAP_MAX) begin
        gap_bits_r <= gap_bits_r + MPR_GAP_BITS_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

//--- mpr_port_rx.sv
/*
  MAC port receive configuration and status: loopback from MAC transmit to receive,
  receive FCS check enable, interframe gap check, frame length limits,
  error counters and receive queue occupancy readback.
  Assumes a simple register port driven by the SPI register map logic,
  MII signals and frame events synchronous to the one system clock.
*/
// Summary of operation
// - Loopback bit set routes MAC transmit nibbles back into receive; clear is normal; resets 0.
// - FCS errors reject frames only while the check enable bit is set; resets 1.
// - Each receive gap must exceed the gap field times eight bit times; field resets 0xA.
// - A gap not above the minimum drops the next frame and raises the gap error flag.
// - Gap field is six bits; software keeps it at 63 or below.
// - Upper frame length limit is 16 bits read-write, in bytes, resetting to 0x618.
// - Lower frame length limit is 16 bits read-write, in bytes, resetting to 0x40.
// - Low priority queue frame count reads back in nine bits, zero after reset.
// - High priority queue frame count reads back in nine bits, zero after reset.
// - Low priority queue half word count reads back in fourteen bits, zero after reset.
// - High priority queue half word count reads back in fourteen bits, zero after reset.
// - Each frame dropped for a short gap increments a 32-bit read-only counter.
// - Each frame outside the length limits, unless already dropped for its gap, increments a 32-bit read-only counter.
`timescale 1ns/10ps
`default_nettype none
module mpr_port_rx
  import mpr_pkg::*;
#(
  parameter int BIT_CYCLES = mpr_pkg::MPR_BIT_CYCLES,
  parameter int CNT_W = 32
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  // Register access port.
  input wire logic [mpr_pkg::MPR_ADDR_W-1:0] REG_ADDR_I,
  input wire logic [mpr_pkg::MPR_DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [mpr_pkg::MPR_DATA_W-1:0] REG_RDATA_O,
  output logic REG_ACK_O,
  // MII from the PHY and toward the PHY.
  input wire logic [mpr_pkg::MPR_NIBBLE_W-1:0] PHY_RXD_I,
  input wire logic PHY_RX_DV_I,
  output logic [mpr_pkg::MPR_NIBBLE_W-1:0] PHY_TXD_O,
  output logic PHY_TX_EN_O,
  // MAC side transmit and receive nibbles.
  input wire logic [mpr_pkg::MPR_NIBBLE_W-1:0] MAC_TXD_I,
  input wire logic MAC_TX_EN_I,
  output logic [mpr_pkg::MPR_NIBBLE_W-1:0] MAC_RXD_O,
  output logic MAC_RX_DV_O,
  // Frame end report from the receive MAC.
  input wire logic RX_FRAME_END_I,
  input wire logic [mpr_pkg::MPR_LEN_W-1:0] RX_FRAME_BYTES_I,
  input wire logic RX_FCS_BAD_I,
  // Queue occupancy from the receive FIFOs.
  input wire logic [mpr_pkg::MPR_FRAMES_W-1:0] LO_FRAMES_I,
  input wire logic [mpr_pkg::MPR_FRAMES_W-1:0] HI_FRAMES_I,
  input wire logic [mpr_pkg::MPR_HALFWORDS_W-1:0] LO_HALFWORDS_I,
  input wire logic [mpr_pkg::MPR_HALFWORDS_W-1:0] HI_HALFWORDS_I,
  // Status and control levels; frame reject is a one-cycle pulse.
  input wire logic RX_GAP_ERR_CLR_I,
  output logic RX_GAP_ERROR_FLAG_O,
  output logic RX_FRAME_REJECT_O,
  output logic RX_FRAME_AVAILABLE_O,
  output logic MAC_LOOPBACK_ENABLE_O,
  output logic RX_FCS_CHECK_ENABLE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic loopback_r;
  logic fcs_check_r;
  logic [MPR_GAP_W-1:0] gap_min_r;
  logic [MPR_LEN_W-1:0] len_upper_r;
  logic [MPR_LEN_W-1:0] len_lower_r;
  logic [MPR_FRAMES_W-1:0] lo_frames_r;
  logic [MPR_FRAMES_W-1:0] hi_frames_r;
  logic [MPR_HALFWORDS_W-1:0] lo_halfwords_r;
  logic [MPR_HALFWORDS_W-1:0] hi_halfwords_r;
  logic [MPR_DATA_W-1:0] rdata_r;
  logic [MPR_DATA_W-1:0] rdata_nxt;
  logic ack_r;
  logic gap_flag_r;
  logic gap_drop_r;
  logic reject_r;
  logic avail_r;
  logic [MPR_NIBBLE_W-1:0] mac_rxd_r;
  logic mac_rx_dv_r;
  logic [MPR_NIBBLE_W-1:0] phy_txd_r;
  logic phy_tx_en_r;

  logic rx_dv_sel;
  logic [MPR_NIBBLE_W-1:0] rxd_sel;
  logic gap_short;
  logic frame_start;
  logic len_err;
  logic fcs_err;
  logic len_err_evt;
  logic wr_loopback;
  logic wr_fcs_check;
  logic wr_gap_min;
  logic wr_len_upper;
  logic wr_len_lower;
  logic [CNT_W-1:0] gap_err_cnt;
  logic [CNT_W-1:0] len_err_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Address match for a write strobe, used by every writable register.
  function automatic logic wr_hit(input logic wr, input logic [MPR_ADDR_W-1:0] addr,
                                  input logic [MPR_ADDR_W-1:0] idx);
    wr_hit = wr & (addr == idx);
  endfunction

  // Zero extension to a bus word so unused upper bits read as zero.
  function automatic logic [MPR_DATA_W-1:0] zext16(input logic [MPR_LEN_W-1:0] v);
    zext16 = {{(MPR_DATA_W-MPR_LEN_W){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Loopback path selection.

  // In loopback the MAC transmit nibbles feed the receive side.
  assign rx_dv_sel = loopback_r ? MAC_TX_EN_I : PHY_RX_DV_I;
  assign rxd_sel = loopback_r ? MAC_TXD_I : PHY_RXD_I;

  // Register the MII paths so every output comes from a flip-flop.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mac_rxd_r <= '0;
      mac_rx_dv_r <= 1'b0;
      phy_txd_r <= '0;
      phy_tx_en_r <= 1'b0;
    end else begin
      mac_rxd_r <= rxd_sel;
      mac_rx_dv_r <= rx_dv_sel;
      phy_txd_r <= MAC_TXD_I;
      phy_tx_en_r <= MAC_TX_EN_I & ~loopback_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interframe gap check on the selected receive stream.

  mpr_gap_check #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_gap (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .rx_dv_i(rx_dv_sel),
    .gap_min_units_i(gap_min_r),
    .gap_short_o(gap_short),
    .frame_start_o(frame_start)
  );

  // Remember that the frame now arriving is to be dropped.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gap_drop_r <= 1'b0;
    end else if (frame_start) begin
      gap_drop_r <= gap_short;
    end else if (RX_FRAME_END_I) begin
      gap_drop_r <= 1'b0;
    end
  end

  // Sticky gap error flag; a new event wins over a clear in the same cycle.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gap_flag_r <= 1'b0;
    end else if (gap_short) begin
      gap_flag_r <= 1'b1;
    end else if (RX_GAP_ERR_CLR_I) begin
      gap_flag_r <= 1'b0;
    end
  end

  mpr_err_counter #(
    .WIDTH(CNT_W)
  ) u_gap_cnt (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .inc_i(gap_short),
    .count_o(gap_err_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame end checks: length limits and FCS.

  assign len_err = (RX_FRAME_BYTES_I < len_lower_r) | (RX_FRAME_BYTES_I > len_upper_r);
  assign fcs_err = RX_FCS_BAD_I & fcs_check_r;
  // Frames already dropped for their gap are not judged again.
  assign len_err_evt = RX_FRAME_END_I & ~gap_drop_r & len_err;

  mpr_err_counter #(
    .WIDTH(CNT_W)
  ) u_len_cnt (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .inc_i(len_err_evt),
    .count_o(len_err_cnt)
  );

  // One-cycle reject pulse after a frame end that must be discarded.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= RX_FRAME_END_I & (gap_drop_r | len_err | fcs_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue occupancy sampling.

  // Occupancy is captured every cycle so a read returns a stable word.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lo_frames_r <= '0;
      hi_frames_r <= '0;
      lo_halfwords_r <= '0;
      hi_halfwords_r <= '0;
      avail_r <= 1'b0;
    end else begin
      lo_frames_r <= LO_FRAMES_I;
      hi_frames_r <= HI_FRAMES_I;
      lo_halfwords_r <= LO_HALFWORDS_I;
      hi_halfwords_r <= HI_HALFWORDS_I;
      avail_r <= (LO_FRAMES_I != '0) | (HI_FRAMES_I != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.

  assign wr_loopback = wr_hit(REG_WR_I, REG_ADDR_I, MPR_IDX_LOOPBACK);
  assign wr_fcs_check = wr_hit(REG_WR_I, REG_ADDR_I, MPR_IDX_FCS_CHECK);
  assign wr_gap_min = wr_hit(REG_WR_I, REG_ADDR_I, MPR_IDX_GAP_MIN);
  assign wr_len_upper = wr_hit(REG_WR_I, REG_ADDR_I, MPR_IDX_LEN_UPPER);
  assign wr_len_lower = wr_hit(REG_WR_I, REG_ADDR_I, MPR_IDX_LEN_LOWER);

  // Only the defined field bits are stored; upper bits are dropped.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      loopback_r <= MPR_RST_LOOPBACK;
      fcs_check_r <= MPR_RST_FCS_CHECK;
      gap_min_r <= MPR_RST_GAP_MIN;
      len_upper_r <= MPR_RST_LEN_UPPER;
      len_lower_r <= MPR_RST_LEN_LOWER;
    end else begin
      if (wr_loopback) begin
        loopback_r <= REG_WDATA_I[0];
      end
      if (wr_fcs_check) begin
        fcs_check_r <= REG_WDATA_I[0];
      end
      if (wr_gap_min) begin
        gap_min_r <= REG_WDATA_I[MPR_GAP_W-1:0];
      end
      if (wr_len_upper) begin
        len_upper_r <= REG_WDATA_I[MPR_LEN_W-1:0];
      end
      if (wr_len_lower) begin
        len_lower_r <= REG_WDATA_I[MPR_LEN_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.

  // Read mux; unmapped indexes and reserved bits return zero.
  always_comb begin
    rdata_nxt = '0;
    case (REG_ADDR_I)
      MPR_IDX_LOOPBACK: rdata_nxt = {{(MPR_DATA_W-1){1'b0}}, loopback_r};
      MPR_IDX_FCS_CHECK: rdata_nxt = {{(MPR_DATA_W-1){1'b0}}, fcs_check_r};
      MPR_IDX_GAP_MIN: rdata_nxt = {{(MPR_DATA_W-MPR_GAP_W){1'b0}}, gap_min_r};
      MPR_IDX_LEN_UPPER: rdata_nxt = zext16(len_upper_r);
      MPR_IDX_LEN_LOWER: rdata_nxt = zext16(len_lower_r);
      MPR_IDX_LO_FRAMES: rdata_nxt = {{(MPR_DATA_W-MPR_FRAMES_W){1'b0}}, lo_frames_r};
      MPR_IDX_HI_FRAMES: rdata_nxt = {{(MPR_DATA_W-MPR_FRAMES_W){1'b0}}, hi_frames_r};
      MPR_IDX_LO_HALFWORDS: rdata_nxt = {{(MPR_DATA_W-MPR_HALFWORDS_W){1'b0}}, lo_halfwords_r};
      MPR_IDX_HI_HALFWORDS: rdata_nxt = {{(MPR_DATA_W-MPR_HALFWORDS_W){1'b0}}, hi_halfwords_r};
      MPR_IDX_GAP_ERR_CNT: rdata_nxt = MPR_DATA_W'(gap_err_cnt);
      MPR_IDX_LEN_ERR_CNT: rdata_nxt = MPR_DATA_W'(len_err_cnt);
      default: rdata_nxt = '0;
    endcase
  end

  // Read data is held until the next read; ack pulses once per access.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= '0;
      ack_r <= 1'b0;
    end else begin
      ack_r <= REG_RD_I | REG_WR_I;
      if (REG_RD_I) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign REG_RDATA_O = rdata_r;
  assign REG_ACK_O = ack_r;
  assign PHY_TXD_O = phy_txd_r;
  assign PHY_TX_EN_O = phy_tx_en_r;
  assign MAC_RXD_O = mac_rxd_r;
  assign MAC_RX_DV_O = mac_rx_dv_r;
  assign RX_GAP_ERROR_FLAG_O = gap_flag_r;
  assign RX_FRAME_REJECT_O = reject_r;
  assign RX_FRAME_AVAILABLE_O = avail_r;
  assign MAC_LOOPBACK_ENABLE_O = loopback_r;
  assign RX_FCS_CHECK_ENABLE_O = fcs_check_r;

endmodule
`default_nettype wire

//--- mpr_phy_model.sv
/*
  Behavioural model of the PHY receive side: idles for a given number of cycles,
  then sends a frame of nibbles with receive data valid high.
  Assumes its tasks are called from the system clock domain by the testbench.
*/
`timescale 1ns/10ps
`default_nettype none
module mpr_phy_model
  import mpr_pkg::*;
(
  input wire logic clk_i,
  output logic [mpr_pkg::MPR_NIBBLE_W-1:0] rxd_o,
  output logic rx_dv_o
);
  ////////////////////////////////////////////////////////////////////////////
  // The line starts idle with valid low.
  initial begin
    rx_dv_o = 1'b0;
    rxd_o = 4'h0;
  end

  // Idle nibbles flip every cycle so that stale data never looks like a frame.
  task automatic send(input int gap, input int len);
    repeat (gap) begin
      @(posedge clk_i);
      #1 rx_dv_o = 1'b0;
      rxd_o = ~rxd_o;
    end
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      #1 rx_dv_o = 1'b1;
      rxd_o = i[3:0];
    end
    @(posedge clk_i);
    #1 rx_dv_o = 1'b0;
    rxd_o = ~rxd_o;
  endtask
endmodule
`default_nettype wire

//--- mpr_port_rx_sva.sv
/*
  Concurrent checks on the ports of the MAC port receive block.
  Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module mpr_port_rx_sva
  import mpr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [mpr_pkg::MPR_DATA_W-1:0] REG_RDATA_O,
  input wire logic REG_ACK_O,
  input wire logic PHY_RX_DV_I,
  input wire logic [mpr_pkg::MPR_NIBBLE_W-1:0] PHY_TXD_O,
  input wire logic PHY_TX_EN_O,
  input wire logic [mpr_pkg::MPR_NIBBLE_W-1:0] MAC_TXD_I,
  input wire logic MAC_TX_EN_I,
  input wire logic MAC_RX_DV_O,
  input wire logic RX_FRAME_END_I,
  input wire logic RX_FCS_BAD_I,
  input wire logic [mpr_pkg::MPR_FRAMES_W-1:0] LO_FRAMES_I,
  input wire logic [mpr_pkg::MPR_FRAMES_W-1:0] HI_FRAMES_I,
  input wire logic RX_GAP_ERR_CLR_I,
  input wire logic RX_GAP_ERROR_FLAG_O,
  input wire logic RX_FRAME_REJECT_O,
  input wire logic RX_FRAME_AVAILABLE_O,
  input wire logic MAC_LOOPBACK_ENABLE_O,
  input wire logic RX_FCS_CHECK_ENABLE_O
);
  ////////////////////////////////////////////////////////////////////////////
  // All checks run on the system clock and pause during reset.
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  // Steps of the multi-cycle behaviours.
  sequence s_req;
    REG_WR_I || REG_RD_I;
  endsequence
  sequence s_loop_held;
    MAC_LOOPBACK_ENABLE_O [*2];
  endsequence
  sequence s_fcs_bad_end;
    RX_FRAME_END_I && RX_FCS_BAD_I && RX_FCS_CHECK_ENABLE_O;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Register port handshake and read data.
  a_ack_after_req: assert property (s_req |=> REG_ACK_O)
    else $error("access not acknowledged one cycle later");
  a_ack_not_spurious: assert property (!(REG_WR_I || REG_RD_I) |=> !REG_ACK_O)
    else $error("acknowledge without an access");
  a_rdata_held: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data changed without a read");

  // Loopback and the normal paths.
  a_loop_tx_quiet: assert property (s_loop_held |-> !PHY_TX_EN_O)
    else $error("transmit enable reached the PHY in loopback");
  a_loop_rx_path: assert property (MAC_LOOPBACK_ENABLE_O |=> MAC_RX_DV_O == $past(MAC_TX_EN_I))
    else $error("loopback receive valid does not follow transmit enable");
  a_phy_rx_path: assert property (!MAC_LOOPBACK_ENABLE_O |=> MAC_RX_DV_O == $past(PHY_RX_DV_I))
    else $error("receive valid does not follow the PHY");
  a_txd_copy: assert property (1'b1 |=> PHY_TXD_O == $past(MAC_TXD_I))
    else $error("transmit nibble not copied toward the PHY");

  // Frame rejection and the gap flag.
  a_fcs_reject: assert property (s_fcs_bad_end |=> RX_FRAME_REJECT_O)
    else $error("bad FCS frame not rejected");
  a_reject_cause: assert property (RX_FRAME_REJECT_O |-> $past(RX_FRAME_END_I))
    else $error("reject without a frame end");
  a_flag_sticky: assert property (RX_GAP_ERROR_FLAG_O && !RX_GAP_ERR_CLR_I |=> RX_GAP_ERROR_FLAG_O)
    else $error("gap error flag dropped without a clear");
  a_flag_cause: assert property ($rose(RX_GAP_ERROR_FLAG_O) && !MAC_LOOPBACK_ENABLE_O
    |-> $past(PHY_RX_DV_I) && !$past(PHY_RX_DV_I, 2))
    else $error("gap error flag rose without a frame start");

  // Frame available follows the queue frame counts.
  a_avail_set: assert property ((LO_FRAMES_I != 0 || HI_FRAMES_I != 0) |=> RX_FRAME_AVAILABLE_O)
    else $error("frame available missing");
  a_avail_clear: assert property ((LO_FRAMES_I == 0 && HI_FRAMES_I == 0) |=> !RX_FRAME_AVAILABLE_O)
    else $error("frame available with empty queues");
endmodule

bind mpr_port_rx mpr_port_rx_sva u_mpr_port_rx_sva (.CLK_I(CLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O), .PHY_RX_DV_I(PHY_RX_DV_I),
  .PHY_TXD_O(PHY_TXD_O), .PHY_TX_EN_O(PHY_TX_EN_O), .MAC_TXD_I(MAC_TXD_I), .MAC_TX_EN_I(MAC_TX_EN_I),
  .MAC_RX_DV_O(MAC_RX_DV_O), .RX_FRAME_END_I(RX_FRAME_END_I), .RX_FCS_BAD_I(RX_FCS_BAD_I),
  .LO_FRAMES_I(LO_FRAMES_I), .HI_FRAMES_I(HI_FRAMES_I), .RX_GAP_ERR_CLR_I(RX_GAP_ERR_CLR_I),
  .RX_GAP_ERROR_FLAG_O(RX_GAP_ERROR_FLAG_O), .RX_FRAME_REJECT_O(RX_FRAME_REJECT_O),
  .RX_FRAME_AVAILABLE_O(RX_FRAME_AVAILABLE_O), .MAC_LOOPBACK_ENABLE_O(MAC_LOOPBACK_ENABLE_O),
  .RX_FCS_CHECK_ENABLE_O(RX_FCS_CHECK_ENABLE_O));
`default_nettype wire

//--- mpr_port_rx_tb.sv
/*
  Self-checking testbench for the MAC port receive block.
  Assumes the PHY model file and the design are compiled first; bit time is shortened to 2 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module mpr_port_rx_tb;
  import mpr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wr = 1'b0, rd = 1'b0, ack, fend = 1'b0, fbad = 1'b0, gclr = 1'b0, mtxen = 1'b0;
  logic [3:0] mtxd = 4'h0, prxd, ptxd, mrxd;
  logic pdv, ptxen, mdv, gflag, rej, avail, loop_o, fcs_o;
  logic [15:0] fbytes = 16'h0000;
  logic [8:0] lof = 9'h000, hif = 9'h000;
  logic [13:0] loh = 14'h0000, hih = 14'h0000;
  logic [31:0] q;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  mpr_port_rx #(.BIT_CYCLES(2), .CNT_W(32)) u_mpr_port_rx (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
    .PHY_RXD_I(prxd), .PHY_RX_DV_I(pdv), .PHY_TXD_O(ptxd), .PHY_TX_EN_O(ptxen), .MAC_TXD_I(mtxd),
    .MAC_TX_EN_I(mtxen), .MAC_RXD_O(mrxd), .MAC_RX_DV_O(mdv), .RX_FRAME_END_I(fend),
    .RX_FRAME_BYTES_I(fbytes), .RX_FCS_BAD_I(fbad), .LO_FRAMES_I(lof), .HI_FRAMES_I(hif),
    .LO_HALFWORDS_I(loh), .HI_HALFWORDS_I(hih), .RX_GAP_ERR_CLR_I(gclr), .RX_GAP_ERROR_FLAG_O(gflag),
    .RX_FRAME_REJECT_O(rej), .RX_FRAME_AVAILABLE_O(avail), .MAC_LOOPBACK_ENABLE_O(loop_o),
    .RX_FCS_CHECK_ENABLE_O(fcs_o));
  mpr_phy_model u_mpr_phy_model (.clk_i(clk), .rxd_o(prxd), .rx_dv_o(pdv));

  // System clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares one value of up to 32 bits.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n edges and lands just after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One register access: a one-cycle strobe, acknowledged on the next edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    step(1);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    step(1);
    wr = 1'b0;
    rd = 1'b0;
    chk({31'h0, ack}, 32'h0000_0001);
    r = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Frame from the PHY model, then its end report; reject is looked at one cycle later.
  task automatic frame(input int gap, input logic [15:0] len, input logic bad, input logic exp_rej);
    u_mpr_phy_model.send(gap, 8);
    fend = 1'b1;
    fbytes = len;
    fbad = bad;
    step(1);
    fend = 1'b0;
    chk({31'h0, rej}, {31'h0, exp_rej});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] ra[12] = '{8'hA6, 8'hAE, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hC0};
    logic [31:0] rv[12] = '{0, 0, 0, 1, 32'h0000_000A, 32'h0000_0618, 32'h0000_0040, 0, 0, 0, 0, 0};
    chk({30'h0, loop_o, fcs_o}, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      rchk(ra[i], rv[i]);
    end
    $display("reset values done");
  endtask

  task automatic t_rw();
    logic [31:0] rv[5] = '{1, 1, 32'h0000_003F, 32'h0000_FFFF, 32'h0000_FFFF};
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 8'hB3 + 8'(i), 32'hFFFF_FFFF, q);
      rchk(8'hB3 + 8'(i), rv[i]);
    end
    chk({31'h0, loop_o}, 32'h0000_0001);
    acc(1'b1, 8'hAE, 32'hFFFF_FFFF, q);
    rchk(8'hAE, 32'h0000_0000);
    acc(1'b1, 8'hB3, 32'h0000_0000, q);
    acc(1'b1, 8'hB5, 32'h0000_000A, q);
    acc(1'b1, 8'hB6, 32'h0000_0618, q);
    acc(1'b1, 8'hB7, 32'h0000_0040, q);
    $display("read write access done");
  endtask

  task automatic t_queues();
    lof = 9'h1FF;
    loh = 14'h3FFF;
    hih = 14'h1234;
    acc(1'b1, 8'hB8, 32'h0000_0000, q);
    rchk(8'hB8, 32'h0000_01FF);
    rchk(8'hBA, 32'h0000_3FFF);
    rchk(8'hBB, 32'h0000_1234);
    chk({31'h0, avail}, 32'h0000_0001);
    lof = 9'h000;
    hif = 9'h101;
    rchk(8'hB9, 32'h0000_0101);
    rchk(8'hB8, 32'h0000_0000);
    hif = 9'h000;
    step(2);
    chk({31'h0, avail}, 32'h0000_0000);
    $display("queue status done");
  endtask

  task automatic t_loop();
    acc(1'b1, 8'hB3, 32'h0000_0001, q);
    mtxen = 1'b1;
    mtxd = 4'hA;
    step(1);
    mtxd = 4'h5;
    chk({26'h0, mdv, ptxen, mrxd}, 32'h0000_002A);
    step(1);
    mtxen = 1'b0;
    acc(1'b1, 8'hB3, 32'h0000_0000, q);
    mtxen = 1'b1;
    step(1);
    mtxen = 1'b0;
    chk({26'h0, mdv, ptxen, ptxd}, 32'h0000_0015);
    $display("loopback done");
  endtask

  task automatic t_fcs();
    frame(300, 16'h0064, 1'b1, 1'b1);
    acc(1'b1, 8'hB4, 32'h0000_0000, q);
    chk({31'h0, fcs_o}, 32'h0000_0000);
    frame(300, 16'h0064, 1'b1, 1'b0);
    acc(1'b1, 8'hB4, 32'h0000_0001, q);
    $display("FCS check done");
  endtask

  task automatic t_len();
    frame(300, 16'h003F, 1'b0, 1'b1);
    frame(300, 16'h0040, 1'b0, 1'b0);
    frame(300, 16'h0618, 1'b0, 1'b0);
    frame(300, 16'h0619, 1'b0, 1'b1);
    rchk(8'hA6, 32'h0000_0002);
    acc(1'b1, 8'hB6, 32'h0000_0100, q);
    frame(300, 16'h0101, 1'b0, 1'b1);
    frame(300, 16'h0100, 1'b0, 1'b0);
    rchk(8'hA6, 32'h0000_0003);
    $display("length limits done");
  endtask

  task automatic t_gap();
    acc(1'b1, 8'hB5, 32'h0000_0002, q);
    frame(60, 16'h0064, 1'b0, 1'b0);
    chk({31'h0, gflag}, 32'h0000_0000);
    // Back to back frames: a gap of g idle cycles measures 1 + (g + 1) / 2 bit times here.
    frame(30, 16'h0020, 1'b0, 1'b1);
    frame(31, 16'h0064, 1'b0, 1'b0);
    chk({31'h0, gflag}, 32'h0000_0001);
    rchk(8'hAE, 32'h0000_0001);
    rchk(8'hA6, 32'h0000_0003);
    gclr = 1'b1;
    step(1);
    gclr = 1'b0;
    step(1);
    chk({31'h0, gflag}, 32'h0000_0000);
    frame(60, 16'h0064, 1'b0, 1'b0);
    rchk(8'hAE, 32'h0000_0001);
    $display("gap check done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_rw();
    t_queues();
    t_loop();
    t_fcs();
    t_len();
    t_gap();
    give_verdict();
  end
endmodule
`default_nettype wire
